// [verilog/ocmd_top.sv]
// output channel source mux, divider and driver control with an APB register slave
//
// Implementation choice: the APB slave port.
`timescale 1ns/100ps
`default_nettype none
`include "ocmd_params.svh"
module ocmd_top (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [`OCMD_ADDR_W-1:0] paddr,
    input wire ocmd_pkg::ocmd_word_t pwdata,
    input wire logic [3:0] pstrb,
    output ocmd_pkg::ocmd_word_t prdata,
    output logic pready,
    output logic pslverr,
    input wire logic synth1_clk,
    input wire logic synth2_clk,
    input wire logic ref_pri_clk,
    input wire logic ref_sec_clk,
    output logic out_p,
    output logic out_p_oe_n,
    output logic out_n,
    output logic out_n_oe_n,
    output ocmd_pkg::ocmd_byte_t tail_current_ma,
    output ocmd_pkg::ocmd_byte_t hcsl_load_ohm
);
    import ocmd_pkg::*;

    ocmd_byte_t output_channel_control;
    ocmd_byte_t output_channel_divider;
    logic [3:0] src_meta;
    logic [3:0] src_sync;
    logic sel_prev;
    logic sel_level;
    logic sel_rise;
    logic div_clk;
    logic bypass;
    logic chan_clk;
    logic access;
    logic hit_control;
    logic hit_divider;
    logic hit_status;
    ocmd_src_e channel_source_select;
    ocmd_fmt_e driver_format;
    ocmd_pin_e driver_current_or_pos_ctrl;
    ocmd_pin_e driver_load_or_neg_ctrl;
    ocmd_byte_t status_value;

    // field views of the control register
    assign channel_source_select =
        ocmd_src_e'(output_channel_control[`OCMD_SRC_MSB:`OCMD_SRC_LSB]);
    assign driver_format = ocmd_fmt_e'(output_channel_control[`OCMD_FMT_MSB:`OCMD_FMT_LSB]);
    assign driver_current_or_pos_ctrl =
        ocmd_pin_e'(output_channel_control[`OCMD_MODE1_MSB:`OCMD_MODE1_LSB]);
    assign driver_load_or_neg_ctrl =
        ocmd_pin_e'(output_channel_control[`OCMD_MODE2_MSB:`OCMD_MODE2_LSB]);

    // bus decode; the access phase completes on the cycle pready is high
    assign access = psel && penable;
    assign hit_control = (paddr == `OCMD_ADDR_CONTROL);
    assign hit_divider = (paddr == `OCMD_ADDR_DIVIDER);
    assign hit_status = (paddr == `OCMD_ADDR_STATUS);

    // two-flop synchronisers for the four source clocks
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            src_meta <= 4'h0;
            src_sync <= 4'h0;
        end else begin
            src_meta <= {ref_sec_clk, ref_pri_clk, synth2_clk, synth1_clk};
            src_sync <= src_meta;
        end
    end

    // source mux from the synchronised levels
    always_comb begin
        case (channel_source_select)
            OCMD_SRC_SYNTH1: sel_level = src_sync[0]; // [RQ1]
            OCMD_SRC_SYNTH2: sel_level = src_sync[1]; // [RQ1]
            OCMD_SRC_REF_PRI: sel_level = src_sync[2]; // [RQ1]
            OCMD_SRC_REF_SEC: sel_level = src_sync[3]; // [RQ1]
            default: sel_level = 1'b0;
        endcase
    end

    // rising edge of the selected source
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sel_prev <= 1'b0;
        end else begin
            sel_prev <= sel_level;
        end
    end
    assign sel_rise = sel_level && !sel_prev;

    ocmd_divider u_divider (
        .pclk(pclk),
        .presetn(presetn),
        .src_rise(sel_rise),
        .div_code(output_channel_divider),
        .div_clk(div_clk)
    );

    // references and a ratio of one pass straight through
    assign bypass = (channel_source_select == OCMD_SRC_REF_PRI) ||
                    (channel_source_select == OCMD_SRC_REF_SEC) || // [RQ2] [RQ7]
                    (output_channel_divider == 8'h00);
    assign chan_clk = bypass ? sel_level : div_clk; // [RQ2] [RQ7]

    // register writes take effect at the completing edge only
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            output_channel_control <= `OCMD_CONTROL_RST;
        end else if (access && pready && pwrite && hit_control && pstrb[0]) begin
            output_channel_control <= pwdata[7:0];
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            output_channel_divider <= `OCMD_DIVIDER_RST;
        end else if (access && pready && pwrite && hit_divider && pstrb[0]) begin
            output_channel_divider <= pwdata[7:0]; // [RQ6]
        end
    end

    // status: live driver state and synchronised source levels
    assign status_value = {bypass, (driver_format != OCMD_FMT_OFF), chan_clk, 1'b0, src_sync};

    // one wait state: pready rises in the second access cycle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= 32'h0000_0000;
        end else if (access && !pready) begin
            pready <= 1'b1;
            pslverr <= !(hit_control || hit_divider || hit_status) || (pwrite && hit_status);
            if (pwrite) begin
                prdata <= 32'h0000_0000;
            end else if (hit_control) begin
                prdata <= {24'h00_0000, output_channel_control};
            end else if (hit_divider) begin
                prdata <= {24'h00_0000, output_channel_divider};
            end else if (hit_status) begin
                prdata <= {24'h00_0000, status_value};
            end else begin
                prdata <= 32'h0000_0000;
            end
        end else begin
            pready <= 1'b0;
            pslverr <= 1'b0;
        end
    end

    // driver pins per format and mode fields
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            out_p <= 1'b0;
            out_n <= 1'b0;
            out_p_oe_n <= 1'b1;
            out_n_oe_n <= 1'b1;
        end else begin
            case (driver_format)
                OCMD_FMT_OFF: begin
                    out_p <= 1'b0; // [RQ3] [RQ8]
                    out_n <= 1'b0;
                    out_p_oe_n <= 1'b1;
                    out_n_oe_n <= 1'b1;
                end
                OCMD_FMT_DIFF: begin
                    out_p <= chan_clk; // [RQ3]
                    out_n <= !chan_clk;
                    out_p_oe_n <= 1'b0;
                    out_n_oe_n <= 1'b0;
                end
                OCMD_FMT_HCSL: begin
                    out_p <= chan_clk; // [RQ3]
                    out_n <= !chan_clk;
                    out_p_oe_n <= (driver_load_or_neg_ctrl == OCMD_PIN_TRISTATE); // [RQ5]
                    out_n_oe_n <= (driver_load_or_neg_ctrl == OCMD_PIN_TRISTATE);
                end
                OCMD_FMT_CMOS: begin
                    out_p <= pin_level(driver_current_or_pos_ctrl, chan_clk); // [RQ4]
                    out_n <= pin_level(driver_load_or_neg_ctrl, chan_clk); // [RQ5]
                    out_p_oe_n <= (driver_current_or_pos_ctrl == OCMD_PIN_TRISTATE);
                    out_n_oe_n <= (driver_load_or_neg_ctrl == OCMD_PIN_TRISTATE);
                end
                default: begin
                    out_p <= 1'b0;
                    out_n <= 1'b0;
                    out_p_oe_n <= 1'b1;
                    out_n_oe_n <= 1'b1;
                end
            endcase
        end
    end

    // analog settings reported as figures; zero when not applicable
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tail_current_ma <= 8'h00;
            hcsl_load_ohm <= 8'h00;
        end else begin
            tail_current_ma <= 8'h00;
            hcsl_load_ohm <= 8'h00;
            if (driver_format == OCMD_FMT_DIFF || driver_format == OCMD_FMT_HCSL) begin
                case (driver_current_or_pos_ctrl)
                    OCMD_PIN_TRISTATE: tail_current_ma <= `OCMD_TAIL_MA_0; // [RQ4]
                    OCMD_PIN_LOW: tail_current_ma <= `OCMD_TAIL_MA_1; // [RQ4]
                    OCMD_PIN_INVERTED: tail_current_ma <= `OCMD_TAIL_MA_2; // [RQ4]
                    OCMD_PIN_TRUE: tail_current_ma <= (driver_format == OCMD_FMT_HCSL) ?
                        `OCMD_TAIL_MA_3_HCSL : `OCMD_TAIL_MA_3_DIFF; // [RQ4]
                    default: tail_current_ma <= 8'h00;
                endcase
            end
            if (driver_format == OCMD_FMT_HCSL) begin
                case (driver_load_or_neg_ctrl)
                    OCMD_PIN_LOW: hcsl_load_ohm <= `OCMD_LOAD_OHM_1; // [RQ5]
                    OCMD_PIN_INVERTED: hcsl_load_ohm <= `OCMD_LOAD_OHM_2; // [RQ5]
                    OCMD_PIN_TRUE: hcsl_load_ohm <= `OCMD_LOAD_OHM_3; // [RQ5]
                    default: hcsl_load_ohm <= 8'h00;
                endcase
            end
        end
    end

    // level of one LVCMOS pin for its control code
    function automatic logic pin_level(input ocmd_pin_e ctrl, input logic clk);
        case (ctrl)
            OCMD_PIN_INVERTED: pin_level = !clk;
            OCMD_PIN_TRUE: pin_level = clk;
            default: pin_level = 1'b0;
        endcase
    endfunction : pin_level
endmodule : ocmd_top
`default_nettype wire

// [verilog/ocmd_params.svh]
// constants for the output channel source mux and divider
// How it works
// RQ1 - source select code 0 picks synthesizer one, 1 synthesizer two, 2 primary ref, 3 secondary ref.
// RQ2 - a reference source bypasses the divider and reaches the driver undivided.
// RQ3 - format code 0 disables, 1 is AC-coupled differential, 2 is HCSL, 3 is LVCMOS.
// RQ4 - mode1 sets tail current 4/6/8/16 mA (8 mA in LVPECL use), or the LVCMOS positive pin.
// RQ5 - mode2 sets the HCSL load tristate/50/100/200 ohm, or the LVCMOS negative pin.
// RQ6 - the 8-bit divider divides by field value plus one, 1 to 256, 0xff giving 256.
// RQ7 - the divider acts only when a synthesizer is the source.
// RQ8 - a disabled format keeps the output inactive whatever source and divider say.
`ifndef OCMD_PARAMS_SVH
`define OCMD_PARAMS_SVH

// register indices, byte address is four times the index
`define OCMD_IDX_CONTROL 8'h2b
`define OCMD_IDX_DIVIDER 8'h2c
`define OCMD_IDX_STATUS 8'h2d
`define OCMD_ADDR_W 12
`define OCMD_ADDR_CONTROL 12'h0ac
`define OCMD_ADDR_DIVIDER 12'h0b0
`define OCMD_ADDR_STATUS 12'h0b4

// reset values
`define OCMD_CONTROL_RST 8'h18
`define OCMD_DIVIDER_RST 8'h05

// control field positions
`define OCMD_SRC_MSB 7
`define OCMD_SRC_LSB 6
`define OCMD_FMT_MSB 5
`define OCMD_FMT_LSB 4
`define OCMD_MODE1_MSB 3
`define OCMD_MODE1_LSB 2
`define OCMD_MODE2_MSB 1
`define OCMD_MODE2_LSB 0

// driver figures
`define OCMD_TAIL_MA_0 8'h04
`define OCMD_TAIL_MA_1 8'h06
`define OCMD_TAIL_MA_2 8'h08
`define OCMD_TAIL_MA_3_HCSL 8'h10
`define OCMD_TAIL_MA_3_DIFF 8'h08
`define OCMD_LOAD_OHM_1 8'h32
`define OCMD_LOAD_OHM_2 8'h64
`define OCMD_LOAD_OHM_3 8'hc8

`endif

// [verilog/ocmd_pkg.sv]
// types shared by the output channel mux and divider
`default_nettype none
package ocmd_pkg;
    typedef logic [7:0] ocmd_byte_t;
    typedef logic [31:0] ocmd_word_t;
    typedef enum logic [1:0] {
        OCMD_SRC_SYNTH1,
        OCMD_SRC_SYNTH2,
        OCMD_SRC_REF_PRI,
        OCMD_SRC_REF_SEC
    } ocmd_src_e;
    typedef enum logic [1:0] {
        OCMD_FMT_OFF,
        OCMD_FMT_DIFF,
        OCMD_FMT_HCSL,
        OCMD_FMT_CMOS
    } ocmd_fmt_e;
    typedef enum logic [1:0] {
        OCMD_PIN_TRISTATE,
        OCMD_PIN_LOW,
        OCMD_PIN_INVERTED,
        OCMD_PIN_TRUE
    } ocmd_pin_e;
endpackage : ocmd_pkg
`default_nettype wire

// [verilog/ocmd_divider.sv]
// integer clock divider counting rising edges of a sampled source clock
`timescale 1ns/100ps
`default_nettype none
module ocmd_divider (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic src_rise,
    input wire ocmd_pkg::ocmd_byte_t div_code,
    output logic div_clk
);
    import ocmd_pkg::*;

    logic [7:0] edge_count;
    logic [8:0] high_count;

    // high phase is the first ceil(ratio/2) source periods
    assign high_count = ({1'b0, div_code} + 9'h002) >> 1;

    // count source edges modulo ratio; ratio is code plus one
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            edge_count <= 8'h00;
        end else if (src_rise) begin
            if (edge_count >= div_code) begin // [RQ6]
                edge_count <= 8'h00;
            end else begin
                edge_count <= edge_count + 8'h01;
            end
        end
    end

    // divided level follows the count phase
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            div_clk <= 1'b0;
        end else if (src_rise) begin
            if (edge_count >= div_code) begin
                div_clk <= 1'b1;
            end else begin
                div_clk <= ({1'b0, edge_count} + 9'h001) < high_count; // [RQ6]
            end
        end
    end
endmodule : ocmd_divider
`default_nettype wire

// [testbench/ocmd_top_props.sv]
// concurrent checks on the output channel mux and divider ports
`timescale 1ns/100ps
`default_nettype none
module ocmd_top_props (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pready,
    input wire logic pslverr,
    input wire ocmd_pkg::ocmd_word_t prdata,
    input wire logic out_p,
    input wire logic out_n,
    input wire logic out_p_oe_n,
    input wire logic out_n_oe_n,
    input wire ocmd_pkg::ocmd_byte_t tail_current_ma,
    input wire ocmd_pkg::ocmd_byte_t hcsl_load_ohm
);
    import ocmd_pkg::*;
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);
    // first access cycle of a transfer, answer due one cycle later
    sequence s_access;
        psel && penable && !pready;
    endsequence
    sequence s_answer;
        pready ##1 !pready;
    endsequence
    a_ready_next: assert property (s_access |=> s_answer) else $error("pready not on time");
    a_ready_cause: assert property (pready |-> $past(psel) && $past(penable))
        else $error("pready without access");
    a_err_ready: assert property (pslverr |-> pready) else $error("pslverr without pready");
    a_rdata_hold: assert property (!pready |-> $stable(prdata)) else $error("prdata moved");
    a_tail_legal: assert property (tail_current_ma inside {8'h00, 8'h04, 8'h06, 8'h08, 8'h10})
        else $error("tail current code");
    a_load_legal: assert property (hcsl_load_ohm inside {8'h00, 8'h32, 8'h64, 8'hc8})
        else $error("hcsl load value");
    a_diff_compl: assert property ((tail_current_ma != 0) && !out_p_oe_n && !out_n_oe_n
        |-> out_n == !out_p) else $error("differential pins not complementary");
    a_off_still: assert property (out_p_oe_n && out_n_oe_n && tail_current_ma == 0
        && hcsl_load_ohm == 0 |-> !out_p && !out_n) else $error("off pins not low");
endmodule : ocmd_top_props
`default_nettype wire

// [testbench/ocmd_rx_model.sv]
// board side model: free running source clocks and a receiver timing out_p
`timescale 1ns/100ps
`default_nettype none
module ocmd_rx_model (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic out_p,
    output logic [3:0] src_clk,
    output int per,
    output int nrise
);
    logic p_d;
    int cnt;
    logic s0 = 1'b0;
    logic s1 = 1'b0;
    logic s2 = 1'b0;
    logic s3 = 1'b0;
    // sources of 8, 10, 14 and 18 pclk periods, slow enough for the sampler; one driver each
    always #400 s0 = ~s0;
    always #500 s1 = ~s1;
    always #700 s2 = ~s2;
    always #900 s3 = ~s3;
    assign src_clk = {s3, s2, s1, s0};
    // receiver counts pclk cycles between rising edges of the positive pin
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            p_d <= 1'b0;
            cnt <= 0;
            per <= 0;
            nrise <= 0;
        end else begin
            p_d <= out_p;
            cnt <= (out_p && !p_d) ? 1 : cnt + 1;
            if (out_p && !p_d) begin
                per <= cnt;
                nrise <= nrise + 1;
            end
        end
    end
endmodule : ocmd_rx_model
`default_nettype wire

// [testbench/ocmd_top_tb_top.sv]
// self-checking bench for the output channel mux and divider
`timescale 1ns/100ps
`default_nettype none
`include "ocmd_params.svh"
module ocmd_top_tb_top;
    import ocmd_pkg::*;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [`OCMD_ADDR_W-1:0] paddr = '0;
    logic [3:0] pstrb = 4'hf;
    ocmd_word_t pwdata = '0;
    ocmd_word_t prdata, rd;
    logic pready, pslverr, out_p, out_n, out_p_oe_n, out_n_oe_n, er, bad;
    ocmd_byte_t tail_current_ma, hcsl_load_ohm;
    logic [3:0] src_clk;
    int per, nrise, n_fail = 0, total_checks = 0;
    int src_exp[4] = '{24, 30, 14, 18};
    ocmd_byte_t dcode[3] = '{8'h00, 8'h01, 8'hff};
    int dexp[3] = '{8, 16, 2048};
    // control byte and expected {tail, load, oe_p_n, oe_n_n, level kind}
    ocmd_byte_t fctl[12] = '{8'h80, 8'h90, 8'h94, 8'h98, 8'h9c, 8'hac, 8'had, 8'hae,
        8'haf, 8'hb0, 8'hb5, 8'hbe};
    logic [19:0] fexp[12] = '{20'h0000d, 20'h04002, 20'h06002, 20'h08002, 20'h08002,
        20'h1000c, 20'h10322, 20'h10642, 20'h10c82, 20'h0000c, 20'h00001, 20'h00002};
    always #50 pclk = ~pclk;
    ocmd_top ocmd_top_i (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
        .pstrb, .prdata, .pready, .pslverr, .synth1_clk(src_clk[0]),
        .synth2_clk(src_clk[1]), .ref_pri_clk(src_clk[2]), .ref_sec_clk(src_clk[3]),
        .out_p, .out_p_oe_n, .out_n, .out_n_oe_n, .tail_current_ma, .hcsl_load_ohm);
    ocmd_rx_model ocmd_rx_model_i (.pclk, .presetn, .out_p, .src_clk, .per, .nrise);
    task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
        total_checks++;
        if (got !== exp) begin
            n_fail++;
            $display("MISMATCH %s expected %h seen %h", nm, exp, got);
        end
    endtask : chk
    // one apb transfer, held until pready is seen high at a rising edge
    task automatic apb(input logic w, input logic [11:0] a, input ocmd_word_t d);
        int n;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 40);
        if (n >= 40) n_fail++;
        // answer taken at the same rising edge that sees pready high
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    // skip two edges after a change, then time one steady period
    task automatic meas(input int exp);
        int n0;
        n0 = nrise;
        for (int i = 0; i < 8000 && nrise < n0 + 3; i++) @(posedge pclk);
        chk("out edges", 1, 32'(nrise >= n0 + 3));
        chk("out period", exp, per);
    endtask : meas
    task automatic print_verdict();
        $display("checks %0d mismatches %0d", total_checks, n_fail);
        if (n_fail == 0 && total_checks > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask : print_verdict
    initial begin
        #3000000;
        n_fail++;
        print_verdict();
    end
    initial begin
        repeat (5) @(posedge pclk);
        presetn <= 1'b1;
        apb(0, `OCMD_ADDR_CONTROL, 0);
        chk("control reset", `OCMD_CONTROL_RST, rd);
        apb(0, `OCMD_ADDR_DIVIDER, 0);
        chk("divider reset", `OCMD_DIVIDER_RST, rd);
        apb(0, 12'h0f0, 0);
        chk("unmapped err", 1, er);
        chk("unmapped data", 0, rd);
        apb(1, `OCMD_ADDR_STATUS, 32'hff);
        chk("status write err", 1, er);
        // ratio 3: synthesizers divided, references pass undivided
        apb(1, `OCMD_ADDR_DIVIDER, 32'h02);
        apb(0, `OCMD_ADDR_DIVIDER, 0);
        chk("divider readback", 32'h02, rd);
        // a write with its low byte strobe off leaves the register alone
        pstrb <= 4'h0;
        apb(1, `OCMD_ADDR_DIVIDER, 32'h33);
        pstrb <= 4'hf;
        apb(0, `OCMD_ADDR_DIVIDER, 0);
        chk("masked write", 32'h02, rd);
        for (int s = 0; s < 4; s++) begin
            apb(1, `OCMD_ADDR_CONTROL, 32'({s[1:0], 6'h18}));
            meas(src_exp[s]);
        end
        for (int k = 0; k < 3; k++) begin
            apb(1, `OCMD_ADDR_DIVIDER, 32'(dcode[k]));
            apb(1, `OCMD_ADDR_CONTROL, 32'h18);
            meas(dexp[k]);
        end
        // status flags: synthesizer source not bypassed, format enabled
        apb(0, `OCMD_ADDR_STATUS, 0);
        chk("status synth", 32'h40, rd & 32'hffff_ffd0);
        // driver formats and modes with the primary reference running
        for (int i = 0; i < 12; i++) begin
            apb(1, `OCMD_ADDR_CONTROL, 32'(fctl[i]));
            repeat (3) @(posedge pclk);
            @(negedge pclk);
            chk("tail current", 32'(fexp[i][19:12]), 32'(tail_current_ma));
            chk("hcsl load", 32'(fexp[i][11:4]), 32'(hcsl_load_ohm));
            chk("enables", 32'(fexp[i][3:2]), 32'({out_p_oe_n, out_n_oe_n}));
            bad = 1'b0;
            repeat (30) begin
                @(negedge pclk);
                if (fexp[i][1:0] == 2'd1 && {out_p, out_n} !== 2'b00) bad = 1'b1;
                if (fexp[i][1:0] == 2'd2 && out_n !== ~out_p) bad = 1'b1;
            end
            chk("pin levels", 0, 32'(bad));
        end
        // status flags: reference source bypassed, format enabled
        apb(0, `OCMD_ADDR_STATUS, 0);
        chk("status ref", 32'hc0, rd & 32'hffff_ffd0);
        print_verdict();
    end
endmodule : ocmd_top_tb_top
bind ocmd_top ocmd_top_props ocmd_top_props_i (.pclk, .presetn, .psel, .penable, .pready,
    .pslverr, .prdata, .out_p, .out_n, .out_p_oe_n, .out_n_oe_n, .tail_current_ma,
    .hcsl_load_ohm);
`default_nettype wire
